// file: src/hceb_regs.sv
// Host configuration, MAC address, EEPROM pin control and self-test register group.
`timescale 1ns/100ps

module hceb_regs
    import hceb_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // Strap pins
    input  wire logic        ENDIAN_STRAP_PIN,
    input  wire logic        BUS_WIDTH_STRAP_PIN,
    input  wire logic        ROM_PRESENCE_STRAP_PIN,
    // Register access port
    input  wire logic [8:0]  REG_ADDR,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [1:0]  REG_BE,
    input  wire logic [15:0] REG_WDATA,
    output logic      [15:0] REG_RDATA,
    // Serial EEPROM pins
    input  wire logic        ROM_DATA_PIN_I,
    output logic             ROM_DATA_PIN_O,
    output logic             ROM_DATA_PIN_OE,
    output logic             ROM_CLOCK_PIN,
    output logic             ROM_SELECT_PIN,
    // Memory self-test engines
    output logic             SELFTEST_START,
    input  wire logic        TX_SELFTEST_COMPLETE,
    input  wire logic        TX_SELFTEST_FAILED,
    input  wire logic [2:0]  TX_SELFTEST_FAIL_COUNT,
    input  wire logic        RX_SELFTEST_COMPLETE,
    input  wire logic        RX_SELFTEST_FAILED,
    input  wire logic [2:0]  RX_SELFTEST_FAIL_COUNT
);

    hceb_state_t st_reg;
    hceb_state_t st_next;

    // ------------------------------------------------------------------
    // Byte-lane merge
    // ------------------------------------------------------------------
    function automatic logic [15:0] merge_be(input logic [15:0] old_val,
                                             input logic [15:0] new_val,
                                             input logic [1:0]  be);
        logic [15:0] res;
        res = old_val;
        if (be[0]) begin
            res[7:0] = new_val[7:0];
        end
        if (be[1]) begin
            res[15:8] = new_val[15:8];
        end
        return res;
    endfunction : merge_be

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic        half_end;
        logic        wr_hit;
        logic [15:0] rd_val;
        half_end = 1'b0;
        wr_hit   = 1'b0;
        rd_val   = 16'h0000;
        st_next  = st_reg;

        // Pins from outside are synchronised before any use.
        st_next.endian_sync   = {st_reg.endian_sync[0], ENDIAN_STRAP_PIN};
        st_next.width_sync    = {st_reg.width_sync[0], BUS_WIDTH_STRAP_PIN};
        st_next.presence_sync = {st_reg.presence_sync[0], ROM_PRESENCE_STRAP_PIN};
        st_next.data_sync     = {st_reg.data_sync[0], ROM_DATA_PIN_I};

        // Serial clock half-period timer for the loader.
        if (st_reg.load_state != LD_IDLE && st_reg.load_state != LD_DONE) begin
            if (st_reg.tick_cnt == SK_HALF_CYC - 8'h01) begin
                st_next.tick_cnt = 8'h00;
                half_end         = 1'b1;
            end else begin
                st_next.tick_cnt = st_reg.tick_cnt + 8'h01;
            end
        end

        // EEPROM loader.
        case (st_reg.load_state)
            LD_IDLE: begin
                st_next.tick_cnt = st_reg.tick_cnt + 8'h01;
                if (st_reg.tick_cnt == STRAP_SETTLE_CYC) begin
                    // Straps are taken once per reset, then held.
                    st_next.endian_flag   = st_reg.endian_sync[1];
                    st_next.presence_flag = st_reg.presence_sync[1];
                    st_next.width16_flag  = st_reg.width_sync[1];
                    st_next.tick_cnt      = 8'h00;
                    if (st_reg.presence_sync[1]) begin
                        st_next.load_state = LD_SEND;
                        st_next.word_addr  = ROM_FIRST_WORD;
                        st_next.shift      = {ROM_READ_CMD, ROM_FIRST_WORD, 7'h00};
                        st_next.bit_cnt    = 5'h00;
                        st_next.ld_cs      = 1'b1;
                    end else begin
                        st_next.load_state = LD_DONE;
                    end
                end
            end
            LD_SEND: begin
                if (half_end) begin
                    st_next.ld_sk = ~st_reg.ld_sk;
                    if (st_reg.ld_sk) begin
                        st_next.shift   = {st_reg.shift[14:0], 1'b0};
                        st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
                        if (st_reg.bit_cnt == ROM_CMD_BITS - 5'h01) begin
                            st_next.bit_cnt    = 5'h00;
                            st_next.load_state = LD_RECV;
                        end
                    end
                end
            end
            LD_RECV: begin
                if (half_end) begin
                    st_next.ld_sk = ~st_reg.ld_sk;
                    if (!st_reg.ld_sk) begin
                        st_next.shift = {st_reg.shift[14:0], st_reg.data_sync[1]};
                    end else begin
                        st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
                        if (st_reg.bit_cnt == ROM_DATA_BITS - 5'h01) begin
                            st_next.ld_cs      = 1'b0;
                            st_next.load_state = LD_GAP;
                            case (st_reg.word_addr)
                                ROM_FIRST_WORD: st_next.mac_low  = st_reg.shift;
                                ROM_MID_WORD:   st_next.mac_mid  = st_reg.shift;
                                default:        st_next.mac_high = st_reg.shift;
                            endcase
                        end
                    end
                end
            end
            LD_GAP: begin
                if (half_end) begin
                    if (st_reg.word_addr == ROM_LAST_WORD) begin
                        st_next.load_state = LD_DONE;
                    end else begin
                        st_next.word_addr  = st_reg.word_addr + 6'h01;
                        st_next.shift      = {ROM_READ_CMD, 6'(st_reg.word_addr + 6'h01), 7'h00};
                        st_next.bit_cnt    = 5'h00;
                        st_next.ld_cs      = 1'b1;
                        st_next.load_state = LD_SEND;
                    end
                end
            end
            LD_DONE: begin
                st_next.ld_sk = 1'b0;
                st_next.ld_cs = 1'b0;
            end
            default: begin
                st_next.load_state = LD_DONE;
            end
        endcase

        // Register writes; MAC writes only touch the registers.
        wr_hit = REG_WR;
        if (wr_hit) begin
            case (REG_ADDR)
                HOST_MAC_ADDR_LOW_OFS: begin
                    st_next.mac_low = merge_be(st_next.mac_low, REG_WDATA, REG_BE);
                end
                HOST_MAC_ADDR_MID_OFS: begin
                    st_next.mac_mid = merge_be(st_next.mac_mid, REG_WDATA, REG_BE);
                end
                HOST_MAC_ADDR_HIGH_OFS: begin
                    st_next.mac_high = merge_be(st_next.mac_high, REG_WDATA, REG_BE);
                end
                EEPROM_PIN_CONTROL_OFS: begin
                    if (REG_BE[0]) begin
                        st_next.sw_dir = REG_WDATA[EEP_DIR_BIT];
                        st_next.sw_en  = REG_WDATA[EEP_EN_BIT];
                        st_next.sw_do  = REG_WDATA[EEP_DO_BIT];
                        st_next.sw_sk  = REG_WDATA[EEP_SK_BIT];
                        st_next.sw_cs  = REG_WDATA[EEP_CS_BIT];
                    end
                end
                GLOBAL_RESET_OFS: begin
                    if (REG_BE[0]) begin
                        st_next.bist_start = REG_WDATA[RSTC_BIST_BIT];
                    end
                end
                default: begin
                    st_next.bist_start = st_next.bist_start;
                end
            endcase
        end

        // Register reads; unlisted bits stay zero.
        case (REG_ADDR)
            CHIP_STRAP_CONFIG_OFS: begin
                rd_val[CFG_ENDIAN_BIT]   = st_reg.endian_flag;
                rd_val[CFG_PRESENCE_BIT] = st_reg.presence_flag;
                rd_val[CFG_BUS8_BIT]     = ~st_reg.width16_flag;
                rd_val[CFG_BUS16_BIT]    = st_reg.width16_flag;
                rd_val[CFG_SHARED_BIT]   = 1'b1;
                rd_val[CFG_CONST_LSB +: 4] = CFG_CONST_VAL;
            end
            HOST_MAC_ADDR_LOW_OFS:  rd_val = st_reg.mac_low;
            HOST_MAC_ADDR_MID_OFS:  rd_val = st_reg.mac_mid;
            HOST_MAC_ADDR_HIGH_OFS: rd_val = st_reg.mac_high;
            EEPROM_PIN_CONTROL_OFS: begin
                rd_val[EEP_EN_BIT]  = st_reg.sw_en;
                rd_val[EEP_DIN_BIT] = st_reg.data_sync[1];
                rd_val[EEP_DO_BIT]  = st_reg.sw_do;
                rd_val[EEP_SK_BIT]  = st_reg.sw_sk;
                rd_val[EEP_CS_BIT]  = st_reg.sw_cs;
            end
            MEM_SELFTEST_INFO_OFS: begin
                rd_val[BIST_DONE_BIT] = TX_SELFTEST_COMPLETE & RX_SELFTEST_COMPLETE;
                rd_val[BIST_TX_CMP_BIT]     = TX_SELFTEST_COMPLETE;
                rd_val[BIST_TX_FAIL_BIT]    = TX_SELFTEST_FAILED;
                rd_val[BIST_TX_CNT_LSB +: 3] = TX_SELFTEST_FAIL_COUNT;
                rd_val[BIST_RX_CMP_BIT]     = RX_SELFTEST_COMPLETE;
                rd_val[BIST_RX_FAIL_BIT]    = RX_SELFTEST_FAILED;
                rd_val[BIST_RX_CNT_LSB +: 3] = RX_SELFTEST_FAIL_COUNT;
            end
            GLOBAL_RESET_OFS: rd_val[RSTC_BIST_BIT] = st_reg.bist_start;
            default:          rd_val = 16'h0000;
        endcase
        if (REG_RD) begin
            st_next.rdata = rd_val;
        end

        // EEPROM pins: loader owns them until it finishes, then software may.
        if (st_reg.load_state != LD_DONE) begin
            st_next.pin_do = st_reg.shift[15];
            st_next.pin_oe = (st_reg.load_state == LD_SEND);
            st_next.pin_sk = st_reg.ld_sk;
            st_next.pin_cs = st_reg.ld_cs;
        end else if (st_reg.sw_en) begin
            st_next.pin_do = st_reg.sw_do;
            st_next.pin_oe = st_reg.sw_dir;
            st_next.pin_sk = st_reg.sw_sk;
            st_next.pin_cs = st_reg.sw_cs;
        end else begin
            st_next.pin_do = 1'b0;
            st_next.pin_oe = 1'b0;
            st_next.pin_sk = 1'b0;
            st_next.pin_cs = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_reg            <= '0;
            st_reg.load_state <= LD_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign REG_RDATA       = st_reg.rdata;
    assign ROM_DATA_PIN_O  = st_reg.pin_do;
    assign ROM_DATA_PIN_OE = st_reg.pin_oe;
    assign ROM_CLOCK_PIN   = st_reg.pin_sk;
    assign ROM_SELECT_PIN  = st_reg.pin_cs;
    assign SELFTEST_START  = st_reg.bist_start;

endmodule : hceb_regs

// file: src/hceb_pkg.sv
// Package with the register map, field positions and timing of the host config block.
package hceb_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [8:0] CHIP_STRAP_CONFIG_OFS  = 9'h108;
    localparam logic [8:0] HOST_MAC_ADDR_LOW_OFS  = 9'h110;
    localparam logic [8:0] HOST_MAC_ADDR_MID_OFS  = 9'h112;
    localparam logic [8:0] HOST_MAC_ADDR_HIGH_OFS = 9'h114;
    localparam logic [8:0] EEPROM_PIN_CONTROL_OFS = 9'h122;
    localparam logic [8:0] MEM_SELFTEST_INFO_OFS  = 9'h124;
    localparam logic [8:0] GLOBAL_RESET_OFS       = 9'h126;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG_ENDIAN_BIT    = 10;
    localparam int CFG_PRESENCE_BIT  = 9;
    localparam int CFG_BUS8_BIT      = 7;
    localparam int CFG_BUS16_BIT     = 6;
    localparam int CFG_SHARED_BIT    = 4;
    localparam int CFG_CONST_LSB     = 0;
    localparam logic [3:0] CFG_CONST_VAL = 4'h2;

    localparam int EEP_DIR_BIT       = 5;
    localparam int EEP_EN_BIT        = 4;
    localparam int EEP_DIN_BIT       = 3;
    localparam int EEP_DO_BIT        = 2;
    localparam int EEP_SK_BIT        = 1;
    localparam int EEP_CS_BIT        = 0;

    localparam int BIST_DONE_BIT     = 15;
    localparam int BIST_TX_CMP_BIT   = 12;
    localparam int BIST_TX_FAIL_BIT  = 11;
    localparam int BIST_TX_CNT_LSB   = 8;
    localparam int BIST_RX_CMP_BIT   = 4;
    localparam int BIST_RX_FAIL_BIT  = 3;
    localparam int BIST_RX_CNT_LSB   = 0;
    localparam int RSTC_BIST_BIT     = 3;

    // ------------------------------------------------------------------
    // Serial EEPROM load sequence
    // ------------------------------------------------------------------
    localparam logic [5:0] ROM_FIRST_WORD = 6'h01;
    localparam logic [5:0] ROM_MID_WORD   = 6'h02;
    localparam logic [5:0] ROM_LAST_WORD  = 6'h03;
    localparam logic [2:0] ROM_READ_CMD   = 3'h6;
    localparam logic [4:0] ROM_CMD_BITS   = 5'h09;
    localparam logic [4:0] ROM_DATA_BITS  = 5'h10;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int SK_HALF_NS      = 1000;
    localparam logic [7:0] SK_HALF_CYC =
        8'((SK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] STRAP_SETTLE_CYC = 8'h03;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        LD_IDLE = 3'h0,
        LD_SEND = 3'h1,
        LD_RECV = 3'h3,
        LD_GAP  = 3'h2,
        LD_DONE = 3'h6
    } hceb_load_t;

    typedef struct packed {
        logic [1:0]  endian_sync;
        logic [1:0]  width_sync;
        logic [1:0]  presence_sync;
        logic [1:0]  data_sync;
        logic        endian_flag;
        logic        presence_flag;
        logic        width16_flag;
        hceb_load_t  load_state;
        logic [7:0]  tick_cnt;
        logic [4:0]  bit_cnt;
        logic [15:0] shift;
        logic [5:0]  word_addr;
        logic        ld_sk;
        logic        ld_cs;
        logic [15:0] mac_low;
        logic [15:0] mac_mid;
        logic [15:0] mac_high;
        logic        sw_dir;
        logic        sw_en;
        logic        sw_do;
        logic        sw_sk;
        logic        sw_cs;
        logic        bist_start;
        logic [15:0] rdata;
        logic        pin_do;
        logic        pin_oe;
        logic        pin_sk;
        logic        pin_cs;
    } hceb_state_t;

endpackage : hceb_pkg

// file: bench/hceb_rom_model.sv
// Behavioural serial EEPROM that serves the host MAC address words.
`timescale 1ns/100ps

module hceb_rom_model #(
    parameter logic [15:0] W1 = 16'h1e2d,
    parameter logic [15:0] W2 = 16'h3c4b,
    parameter logic [15:0] W3 = 16'h5a69
) (
    // Serial pins
    input  wire logic       sk,
    input  wire logic       cs,
    input  wire logic       din,
    output logic            dout,
    // Count of words sent in full
    output logic [3:0]      words
);
    logic [15:0] mem [0:63];
    logic [15:0] sh;
    logic [5:0]  adr;
    logic [4:0]  cnt;

    // The store is never written, so register traffic cannot alter it.
    initial begin
        mem[1] = W1;
        mem[2] = W2;
        mem[3] = W3;
        dout = 1'b0;
        words = 4'h0;
        cnt = 5'h00;
    end

    always @(posedge sk or negedge cs) begin
        if (!cs) begin
            cnt <= 5'h00;
        end else begin
            cnt <= cnt + 5'h01;
            adr <= {adr[4:0], din};
            if (cnt == 5'h08) sh <= mem[{adr[4:0], din}];
            if (cnt == 5'h18) words <= words + 4'h1;
        end
    end

    // Outside the data phase the line toggles on every falling sk or cs edge, so a stale level is never seen.
    always @(negedge sk or negedge cs) begin
        if (!cs || cnt < 5'h09 || cnt > 5'h18) begin
            dout <= ~dout;
        end else begin
            dout <= sh[15];
            sh <= {sh[14:0], 1'b0};
        end
    end
endmodule : hceb_rom_model

// file: bench/hceb_regs_sva.sv
// Port assertions for the host config register group, bound into the design.
`timescale 1ns/100ps

module hceb_regs_chk
    import hceb_pkg::*;
(
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RST,
    // Register access port
    input wire logic [8:0]  REG_ADDR,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [1:0]  REG_BE,
    input wire logic [15:0] REG_WDATA,
    input wire logic [15:0] REG_RDATA,
    // Pin and self-test
    input wire logic        ROM_DATA_PIN_I,
    input wire logic        SELFTEST_START,
    input wire logic        TX_SELFTEST_COMPLETE,
    input wire logic        TX_SELFTEST_FAILED,
    input wire logic [2:0]  TX_SELFTEST_FAIL_COUNT,
    input wire logic        RX_SELFTEST_COMPLETE,
    input wire logic        RX_SELFTEST_FAILED,
    input wire logic [2:0]  RX_SELFTEST_FAIL_COUNT
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    logic [1:0] up_cnt;
    logic       rd_cfg;
    logic       rd_eep;
    logic       rd_bist;
    logic       wr_rstc;
    assign rd_cfg = REG_RD && REG_ADDR == CHIP_STRAP_CONFIG_OFS;
    assign rd_eep = REG_RD && REG_ADDR == EEPROM_PIN_CONTROL_OFS;
    assign rd_bist = REG_RD && REG_ADDR == MEM_SELFTEST_INFO_OFS;
    assign wr_rstc = REG_WR && REG_ADDR == GLOBAL_RESET_OFS;

    // The data pin history is only trusted once the input synchroniser has refilled.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) up_cnt <= 2'h0;
        else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
    end

    property p_cfg_fixed;
        rd_cfg |=> REG_RDATA[5:0] == 6'h12 && REG_RDATA[15:11] == 5'h00 && !REG_RDATA[8];
    endproperty
    a_cfg_fixed: assert property (p_cfg_fixed)
        else $error("strap config constant bits wrong");
    property p_cfg_width;
        rd_cfg |=> REG_RDATA[7] != REG_RDATA[6];
    endproperty
    a_cfg_width: assert property (p_cfg_width)
        else $error("bus width flags not exclusive");
    property p_bist_done;
        rd_bist |=> REG_RDATA[15] == ($past(TX_SELFTEST_COMPLETE) && $past(RX_SELFTEST_COMPLETE));
    endproperty
    a_bist_done: assert property (p_bist_done)
        else $error("self-test done flag wrong");
    property p_bist_tx;
        rd_bist |=> REG_RDATA[12] == $past(TX_SELFTEST_COMPLETE)
            && REG_RDATA[11] == $past(TX_SELFTEST_FAILED)
            && REG_RDATA[10:8] == $past(TX_SELFTEST_FAIL_COUNT);
    endproperty
    a_bist_tx: assert property (p_bist_tx)
        else $error("transmit self-test fields wrong");
    property p_bist_rx;
        rd_bist |=> REG_RDATA[4] == $past(RX_SELFTEST_COMPLETE)
            && REG_RDATA[3] == $past(RX_SELFTEST_FAILED)
            && REG_RDATA[2:0] == $past(RX_SELFTEST_FAIL_COUNT)
            && REG_RDATA[14:13] == 2'h0 && REG_RDATA[7:5] == 3'h0;
    endproperty
    a_bist_rx: assert property (p_bist_rx)
        else $error("receive self-test fields wrong");
    property p_start;
        wr_rstc && REG_BE[0] |=> SELFTEST_START == $past(REG_WDATA[3]);
    endproperty
    a_start: assert property (p_start)
        else $error("self-test start level wrong");
    property p_start_hold;
        !wr_rstc |=> $stable(SELFTEST_START);
    endproperty
    a_start_hold: assert property (p_start_hold)
        else $error("self-test start changed without a write");
    property p_eep_rd;
        rd_eep |=> REG_RDATA[15:5] == 11'h000;
    endproperty
    a_eep_rd: assert property (p_eep_rd)
        else $error("EEPROM control upper bits not zero");
    property p_din;
        rd_eep && up_cnt == 2'h3 && ROM_DATA_PIN_I == $past(ROM_DATA_PIN_I)
            && ROM_DATA_PIN_I == $past(ROM_DATA_PIN_I, 2)
            && ROM_DATA_PIN_I == $past(ROM_DATA_PIN_I, 3)
            |=> REG_RDATA[3] == $past(ROM_DATA_PIN_I);
    endproperty
    a_din: assert property (p_din)
        else $error("EEPROM data status bit wrong");
    property p_unmapped;
        REG_RD && REG_ADDR == 9'h100 |=> REG_RDATA == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    c_bist_fail: cover property (rd_bist && TX_SELFTEST_FAILED);
    c_start: cover property ($rose(SELFTEST_START));
    c_din: cover property (rd_eep && ROM_DATA_PIN_I);
endmodule : hceb_regs_chk

bind hceb_regs hceb_regs_chk hceb_regs_chk_i (
    .CLK, .RST, .REG_ADDR, .REG_WR, .REG_RD, .REG_BE, .REG_WDATA, .REG_RDATA,
    .ROM_DATA_PIN_I, .SELFTEST_START, .TX_SELFTEST_COMPLETE, .TX_SELFTEST_FAILED,
    .TX_SELFTEST_FAIL_COUNT, .RX_SELFTEST_COMPLETE, .RX_SELFTEST_FAILED,
    .RX_SELFTEST_FAIL_COUNT
);

// file: bench/tb_host_config_eeprom_bist_regs.sv
// Self-checking bench for the host config register group with its EEPROM.
`timescale 1ns/100ps

module tb_host_config_eeprom_bist_regs
    import hceb_pkg::*;
;
    localparam logic [15:0] W1 = 16'h2c17;
    localparam logic [15:0] W2 = 16'h7a03;
    localparam logic [15:0] W3 = 16'h44e9;
    logic        clk, rst, st_e, st_w, st_p, ce, cw, cp, wr, rd, rd_seen;
    logic        din_w, do_o, do_oe, sk, cs, start, mdl_d, tx_c, tx_f, rx_c, rx_f;
    logic [8:0]  addr;
    logic [1:0]  be;
    logic [2:0]  tx_n, rx_n;
    logic [3:0]  words;
    logic [15:0] wdata, rdata, v;
    logic [15:0] expq [$];
    int          seed, fail_count, cmp_count, n, i;
    assign din_w = do_oe ? do_o : mdl_d;

    hceb_regs hceb_regs_i (
        .CLK(clk), .RST(rst), .ENDIAN_STRAP_PIN(st_e), .BUS_WIDTH_STRAP_PIN(st_w),
        .ROM_PRESENCE_STRAP_PIN(st_p), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
        .REG_BE(be), .REG_WDATA(wdata), .REG_RDATA(rdata), .ROM_DATA_PIN_I(din_w),
        .ROM_DATA_PIN_O(do_o), .ROM_DATA_PIN_OE(do_oe), .ROM_CLOCK_PIN(sk),
        .ROM_SELECT_PIN(cs), .SELFTEST_START(start), .TX_SELFTEST_COMPLETE(tx_c),
        .TX_SELFTEST_FAILED(tx_f), .TX_SELFTEST_FAIL_COUNT(tx_n),
        .RX_SELFTEST_COMPLETE(rx_c), .RX_SELFTEST_FAILED(rx_f), .RX_SELFTEST_FAIL_COUNT(rx_n));
    hceb_rom_model #(.W1(W1), .W2(W2), .W3(W3)) hceb_rom_model_i (
        .sk(sk), .cs(cs), .din(din_w), .dout(mdl_d), .words(words));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    // One register access; a read notes its expected data for the monitor.
    task automatic acc(input logic w, input logic [8:0] a, input logic [15:0] d,
                       input logic [1:0] b);
        @(posedge clk);
        #1 {addr, wdata, be, wr, rd} = {a, d, b, w, !w};
        if (!w) expq.push_back(d);
        @(posedge clk);
        #1 {wr, rd} = 2'b00;
    endtask : acc

    task automatic do_reset(input logic p);
        rst = 1'b1;
        {st_e, st_w} = 2'($random(seed));
        st_p = p;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        {ce, cw, cp} = {st_e, st_w, st_p};
    endtask : do_reset

    function automatic logic [15:0] cfg_exp(input logic e, input logic p, input logic w);
        return {5'h00, e, p, 1'b0, ~w, w, 2'b01, 4'h2};
    endfunction : cfg_exp

    always @(posedge clk) begin
        if (rd_seen) chk("read data", expq.pop_front(), rdata);
        rd_seen = rd;
    end

    initial begin
        #300000;
        fail_count++;
        $display("watchdog expired");
        wrap_up();
    end

    initial begin
        seed = 34;
        {fail_count, cmp_count, rd_seen, wr, rd, addr, be, wdata} = '0;
        {tx_c, tx_f, tx_n, rx_c, rx_f, rx_n} = 10'h000;
        do_reset(1'b1);
        repeat (10) @(posedge clk);
        #1 {st_e, st_w, st_p} = ~{ce, cw, cp};
        acc(1'b0, CHIP_STRAP_CONFIG_OFS, cfg_exp(ce, cp, cw), 2'h3);
        n = 0;
        while ((words != 4'h3 || cs !== 1'b0) && n < 40000) begin
            @(posedge clk);
            n++;
        end
        chk("load wait", 16'h0000, {15'h0000, n >= 40000});
        // The loader keeps the pins for one more half period after the last word.
        repeat (SK_HALF_CYC + 8'h04) @(posedge clk);
        acc(1'b0, HOST_MAC_ADDR_LOW_OFS, W1, 2'h3);
        acc(1'b0, HOST_MAC_ADDR_MID_OFS, W2, 2'h3);
        acc(1'b0, HOST_MAC_ADDR_HIGH_OFS, W3, 2'h3);
        $display("test load done");
        for (i = 0; i < 3; i++) begin
            v = 16'($random(seed));
            acc(1'b1, HOST_MAC_ADDR_LOW_OFS + 9'(2 * i), v, 2'h3);
            acc(1'b0, HOST_MAC_ADDR_LOW_OFS + 9'(2 * i), v, 2'h3);
        end
        chk("rom words", 16'h0003, {12'h000, words});
        $display("test mac done");
        for (i = 0; i < 8; i++) begin
            v = 16'($random(seed));
            v[4] = i[1] | i[0];
            acc(1'b1, EEPROM_PIN_CONTROL_OFS, v, 2'h3);
            repeat (3) @(posedge clk);
            #1 chk("pins", {12'h000, {4{v[4]}} & {v[5], v[2:0]}},
                   {12'h000, do_oe, do_o, sk, cs});
            acc(1'b0, EEPROM_PIN_CONTROL_OFS, {11'h000, v[4],
                v[4] & v[5] ? v[2] : mdl_d, v[2:0]}, 2'h3);
        end
        acc(1'b1, EEPROM_PIN_CONTROL_OFS, 16'h0000, 2'h3);
        $display("test pins done");
        for (i = 0; i < 8; i++) begin
            acc(1'b1, GLOBAL_RESET_OFS, {12'h000, i[0], 3'h0}, 2'h1);
            {tx_c, tx_f, tx_n, rx_c, rx_f, rx_n} = 10'($random(seed));
            acc(1'b0, MEM_SELFTEST_INFO_OFS, {tx_c & rx_c, 2'h0, tx_c, tx_f, tx_n,
                3'h0, rx_c, rx_f, rx_n}, 2'h3);
            chk("start", {15'h0000, i[0]}, {15'h0000, start});
        end
        acc(1'b1, GLOBAL_RESET_OFS, 16'h0000, 2'h1);
        acc(1'b1, GLOBAL_RESET_OFS, 16'h0008, 2'h2);
        chk("start", 16'h0000, {15'h0000, start});
        $display("test selftest done");
        do_reset(1'b0);
        repeat (6) @(posedge clk);
        #1 chk("pins", 16'h0000, {12'h000, do_oe, do_o, sk, cs});
        acc(1'b0, EEPROM_PIN_CONTROL_OFS, {12'h000, mdl_d, 3'h0}, 2'h3);
        acc(1'b0, HOST_MAC_ADDR_LOW_OFS, 16'h0000, 2'h3);
        acc(1'b1, CHIP_STRAP_CONFIG_OFS, 16'hffff, 2'h3);
        acc(1'b0, CHIP_STRAP_CONFIG_OFS, cfg_exp(ce, cp, cw), 2'h3);
        acc(1'b1, 9'h10a, 16'hffff, 2'h3);
        acc(1'b0, 9'h10a, 16'h0000, 2'h3);
        acc(1'b0, 9'h100, 16'h0000, 2'h3);
        // Let the monitor take the last read before the verdict.
        repeat (2) @(posedge clk);
        #1 chk("queue left", 16'h0000, 16'(expq.size()));
        $display("test reserved done");
        wrap_up();
    end
endmodule : tb_host_config_eeprom_bist_regs
